// File: design/mrf_mode_regs.sv
// Top: mode register file reached by read and write commands
// ==========================================================
`timescale 1ns/1ps
module mrf_mode_regs
  import mrf_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       cmdValid,
  input  wire logic       cmdIsWrite,
  input  wire logic [7:0] modeRegAddress,
  input  wire logic [7:0] operandBits,
  input  wire logic       calPinToRail,
  input  wire logic       calPinToGnd,
  output logic            dqsToggle,
  output logic            dqsOe,
  output logic [7:0]      dqLow,
  output logic            autoInitStatus,
  output logic            useFactoryTrim,
  output logic            calBusy,
  output logic            dqCalActive,
  output logic [7:0]      burstCfg,
  output logic [7:0]      latencyCfg,
  output logic [7:0]      ioDriveCfg,
  output logic [7:0]      srBankMask,
  output logic [7:0]      srSegmentMask
);
  // ==========================================================
  // Command sampling
  logic       cmdValid_r;
  logic       cmdIsWrite_r;
  logic [7:0] addr_r;
  logic [7:0] operand_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmdValid_r   <= 1'b0;
      cmdIsWrite_r <= 1'b0;
      addr_r       <= 8'h00;
      operand_r    <= 8'h00;
    end else begin
      cmdValid_r   <= cmdValid;
      cmdIsWrite_r <= cmdIsWrite;
      addr_r       <= modeRegAddress;
      operand_r    <= operandBits;
    end
  end
  mrf_cmd_t cmdKind;
  always_comb begin
    if (!cmdValid_r)
      cmdKind = MRF_CMD_NONE;
    else if (cmdIsWrite_r)
      cmdKind = MRF_CMD_WRITE;
    else
      cmdKind = MRF_CMD_READ;
  end
  logic wrEn;
  assign wrEn = (cmdKind == MRF_CMD_WRITE);
  // ==========================================================
  // Writable configuration registers
  logic [7:0] testMode_r;
  logic       softReset_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || softReset_r) begin
      burstCfg      <= MRF_RST_CFG;
      latencyCfg    <= MRF_RST_CFG;
      ioDriveCfg    <= MRF_RST_CFG;
      testMode_r    <= MRF_RST_CFG;
      srBankMask    <= MRF_RST_CFG;
      srSegmentMask <= MRF_RST_CFG;
    end else if (wrEn) begin
      // Read-only and reserved addresses fall through untouched
      case (addr_r)
        MRF_ADDR_BURST_CFG:   burstCfg      <= operand_r;
        MRF_ADDR_LATENCY_CFG: latencyCfg    <= operand_r;
        MRF_ADDR_IO_DRIVE:    ioDriveCfg    <= operand_r;
        MRF_ADDR_TEST_MODE:   testMode_r    <= operand_r;
        MRF_ADDR_SR_BANK:     srBankMask    <= operand_r;
        MRF_ADDR_SR_SEGMENT:  srSegmentMask <= operand_r;
        default: ;
      endcase
    end
  end
  // ==========================================================
  // Special operations
  logic calStart;
  logic calInit;
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      softReset_r <= 1'b0;
    else
      softReset_r <= wrEn && addr_r == MRF_ADDR_SOFT_RESET;
  end
  assign calStart = wrEn && addr_r == MRF_ADDR_IMP_CAL;
  assign calInit  = (operand_r == MRF_CAL_INIT);
  // DQ calibration: read of a pattern register drives the pattern
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      dqCalActive <= 1'b0;
    else
      dqCalActive <= (cmdKind == MRF_CMD_READ) &&
                     (addr_r == MRF_ADDR_DQ_PAT_A ||
                      addr_r == MRF_ADDR_DQ_PAT_B);
  end
  // ==========================================================
  // Auto-initialization timer
  // Runs the full maximum time; early finish would need analog status
  logic [8:0] initCnt_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || softReset_r) begin
      autoInitStatus <= 1'b1;
      initCnt_r      <= 9'(MRF_AUTO_INIT_CYC - 1);
    end else if (initCnt_r != 9'h000) begin
      initCnt_r <= initCnt_r - 9'h001;
    end else begin
      autoInitStatus <= 1'b0;
    end
  end
  // ==========================================================
  // Impedance self-test
  logic [1:0] selftestResult;
  mrf_selftest u_selftest (
    .ref_clk        (ref_clk),
    .sys_rst        (sys_rst),
    .calStart       (calStart),
    .calInit        (calInit),
    .pinToRail      (calPinToRail),
    .pinToGnd       (calPinToGnd),
    .selftestResult (selftestResult),
    .calBusy        (calBusy),
    .useFactoryTrim (useFactoryTrim)
  );
  // ==========================================================
  // Read data mux
  logic [7:0] deviceInfo;
  always_comb begin
    deviceInfo = 8'h00;
    deviceInfo[MRF_BIT_AUTO_INIT] = autoInitStatus;
    deviceInfo[MRF_BIT_DEV_KIND]  = MRF_DEV_KIND_SDRAM;
    deviceInfo[MRF_BIT_DATA_INV]  = 1'b0;
    deviceInfo[MRF_LSB_SELFTEST +: 2] = selftestResult;
  end
  mrf_cmd_if cmdBus ();
  always_comb begin
    case (addr_r)
      MRF_ADDR_DEVICE_INFO: cmdBus.rdData = deviceInfo;
      MRF_ADDR_REFRESH:     cmdBus.rdData = MRF_REFRESH_VAL;
      MRF_ADDR_VENDOR:      cmdBus.rdData = MRF_VENDOR_ID;
      MRF_ADDR_REV_ONE:     cmdBus.rdData = MRF_REV_ONE_VAL;
      MRF_ADDR_REV_TWO:     cmdBus.rdData = MRF_REV_TWO_VAL;
      MRF_ADDR_GEOMETRY:    cmdBus.rdData = MRF_GEOMETRY_VAL;
      MRF_ADDR_DQ_PAT_A:    cmdBus.rdData = MRF_DQ_PAT_A_VAL;
      MRF_ADDR_DQ_PAT_B:    cmdBus.rdData = MRF_DQ_PAT_B_VAL;
      default:              cmdBus.rdData = MRF_UNDEF_DATA;
    endcase
  end
  // Reads arriving during a burst are dropped, not queued
  assign cmdBus.rdReq = (cmdKind == MRF_CMD_READ);
  assign cmdBus.addr  = addr_r;
  logic [3:0] readLatency;
  assign readLatency = (latencyCfg[3:0] == 4'h0) ?
                       4'(MRF_RL_DEFAULT) : latencyCfg[3:0];
  mrf_read_burst u_burst (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .readLatency (readLatency),
    .cmd         (cmdBus.burst),
    .dqsToggle   (dqsToggle),
    .dqsOe       (dqsOe),
    .dqLow       (dqLow)
  );
endmodule : mrf_mode_regs

// File: design/mrf_pkg.sv
// Package: constants and types of the mode register file
package mrf_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [7:0] MRF_ADDR_DEVICE_INFO = 8'h00;
  localparam logic [7:0] MRF_ADDR_BURST_CFG   = 8'h01;
  localparam logic [7:0] MRF_ADDR_LATENCY_CFG = 8'h02;
  localparam logic [7:0] MRF_ADDR_IO_DRIVE    = 8'h03;
  localparam logic [7:0] MRF_ADDR_REFRESH     = 8'h04;
  localparam logic [7:0] MRF_ADDR_VENDOR      = 8'h05;
  localparam logic [7:0] MRF_ADDR_REV_ONE     = 8'h06;
  localparam logic [7:0] MRF_ADDR_REV_TWO     = 8'h07;
  localparam logic [7:0] MRF_ADDR_GEOMETRY    = 8'h08;
  localparam logic [7:0] MRF_ADDR_TEST_MODE   = 8'h09;
  localparam logic [7:0] MRF_ADDR_IMP_CAL     = 8'h0a;
  localparam logic [7:0] MRF_ADDR_SR_BANK     = 8'h10;
  localparam logic [7:0] MRF_ADDR_SR_SEGMENT  = 8'h11;
  localparam logic [7:0] MRF_ADDR_DQ_PAT_A    = 8'h20;
  localparam logic [7:0] MRF_ADDR_DQ_PAT_B    = 8'h28;
  localparam logic [7:0] MRF_ADDR_SOFT_RESET  = 8'h3f;
  // ==========================================================
  // Device info field positions
  localparam int MRF_BIT_AUTO_INIT   = 0;
  localparam int MRF_BIT_DEV_KIND    = 1;
  localparam int MRF_BIT_DATA_INV    = 2;
  localparam int MRF_LSB_SELFTEST    = 3;
  // ==========================================================
  // Reset and fixed values
  localparam logic [7:0] MRF_RST_CFG       = 8'h00;
  localparam logic       MRF_DEV_KIND_SDRAM = 1'b0;
  localparam logic [1:0] MRF_ST_NOT_RUN    = 2'b00;
  localparam logic [1:0] MRF_ST_TO_RAIL    = 2'b01;
  localparam logic [1:0] MRF_ST_TO_GND     = 2'b10;
  localparam logic [1:0] MRF_ST_OK         = 2'b11;
  localparam logic [7:0] MRF_VENDOR_ID     = 8'h5a; // Arbitrary value
  localparam logic [7:0] MRF_REV_ONE_VAL   = 8'h01; // Arbitrary value
  localparam logic [7:0] MRF_REV_TWO_VAL   = 8'h00; // Arbitrary value
  localparam logic [7:0] MRF_GEOMETRY_VAL  = 8'h00;
  localparam logic [7:0] MRF_REFRESH_VAL   = 8'h03;
  localparam logic [7:0] MRF_DQ_PAT_A_VAL  = 8'h00;
  localparam logic [7:0] MRF_DQ_PAT_B_VAL  = 8'h00;
  localparam logic [7:0] MRF_UNDEF_DATA    = 8'h00;
  // ==========================================================
  // Timing
  localparam int MRF_CLK_PERIOD_PS   = 25000;
  localparam int MRF_AUTO_INIT_MAX_US = 10;
  localparam int MRF_AUTO_INIT_CYC   =
    (MRF_AUTO_INIT_MAX_US * 1000000) / MRF_CLK_PERIOD_PS;
  localparam int MRF_CAL_TIME_US     = 1;
  localparam int MRF_CAL_CYC         =
    (MRF_CAL_TIME_US * 1000000 + MRF_CLK_PERIOD_PS - 1) / MRF_CLK_PERIOD_PS;
  localparam int MRF_RL_DEFAULT      = 3;
  localparam int MRF_BURST_BEATS     = 4;
  // Calibration operand codes
  localparam logic [7:0] MRF_CAL_INIT      = 8'hff;
  localparam logic [7:0] MRF_CAL_LONG      = 8'hab;
  localparam logic [7:0] MRF_CAL_SHORT     = 8'h56;
  localparam logic [7:0] MRF_CAL_RESET     = 8'hc3;
  typedef enum logic [1:0] {MRF_CMD_NONE, MRF_CMD_READ, MRF_CMD_WRITE}
    mrf_cmd_t;
endpackage : mrf_pkg

// File: design/mrf_cmd_if.sv
// Interface: decoded mode register requests between modules
`timescale 1ns/1ps
interface mrf_cmd_if;
  logic       rdReq;
  logic [7:0] addr;
  logic [7:0] rdData;
  logic       burstBusy;
  modport core  (output rdReq, output addr, output rdData,
                 input burstBusy);
  modport burst (input rdReq, input addr, input rdData,
                 output burstBusy);
endinterface : mrf_cmd_if

// File: design/mrf_read_burst.sv
// Read burst generator: latency, strobe and data byte
`timescale 1ns/1ps
module mrf_read_burst
  import mrf_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] readLatency,
  mrf_cmd_if.burst        cmd,
  output logic            dqsToggle,
  output logic            dqsOe,
  output logic [7:0]      dqLow
);
  // ==========================================================
  // Latency and beat counting
  logic [3:0] latCnt_r;
  logic [2:0] beatCnt_r;
  logic       waiting_r;
  logic [7:0] hold_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      latCnt_r  <= 4'h0;
      beatCnt_r <= 3'h0;
      waiting_r <= 1'b0;
      hold_r    <= 8'h00;
    end else if (cmd.rdReq && !cmd.burstBusy) begin
      latCnt_r  <= readLatency;
      waiting_r <= 1'b1;
      hold_r    <= cmd.rdData;
    end else if (waiting_r) begin
      if (latCnt_r <= 4'h1) begin
        waiting_r <= 1'b0;
        beatCnt_r <= 3'(MRF_BURST_BEATS);
      end else begin
        latCnt_r <= latCnt_r - 4'h1;
      end
    end else if (beatCnt_r != 3'h0) begin
      beatCnt_r <= beatCnt_r - 3'h1;
    end
  end
  assign cmd.burstBusy = waiting_r || (beatCnt_r != 3'h0);
  // ==========================================================
  // Strobe and data drive
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dqsToggle <= 1'b0;
      dqsOe     <= 1'b0;
      dqLow     <= 8'h00;
    end else begin
      dqsOe     <= (beatCnt_r != 3'h0);
      dqsToggle <= (beatCnt_r != 3'h0) ? ~dqsToggle : 1'b0;
      dqLow     <= (beatCnt_r != 3'h0) ? hold_r : 8'h00;
    end
  end
endmodule : mrf_read_burst

// File: design/mrf_selftest.sv
// Impedance pin self-test and calibration lockout
`timescale 1ns/1ps
module mrf_selftest
  import mrf_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       calStart,
  input  wire logic       calInit,
  input  wire logic       pinToRail,
  input  wire logic       pinToGnd,
  output logic [1:0]      selftestResult,
  output logic            calBusy,
  output logic            useFactoryTrim
);
  // ==========================================================
  // Pin synchronisers
  logic [1:0] railSync_r;
  logic [1:0] gndSync_r;
  always_ff @(posedge ref_clk) begin
    railSync_r <= {railSync_r[0], pinToRail};
    gndSync_r  <= {gndSync_r[0], pinToGnd};
  end
  // ==========================================================
  // Calibration timer
  logic [7:0] calCnt_r;
  logic       initRun_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      calCnt_r  <= 8'h00;
      initRun_r <= 1'b0;
    end else if (calStart && !useFactoryTrim && calCnt_r == 8'h00) begin
      calCnt_r  <= 8'(MRF_CAL_CYC);
      initRun_r <= calInit;
    end else if (calCnt_r != 8'h00) begin
      calCnt_r <= calCnt_r - 8'h01;
    end
  end
  assign calBusy = (calCnt_r != 8'h00);
  // ==========================================================
  // Result update on end of initial calibration
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      selftestResult <= MRF_ST_NOT_RUN;
    end else if (initRun_r && calCnt_r == 8'h01) begin
      if (railSync_r[1])
        selftestResult <= MRF_ST_TO_RAIL;
      else if (gndSync_r[1])
        selftestResult <= MRF_ST_TO_GND;
      else
        selftestResult <= MRF_ST_OK;
    end
  end
  // Assembly fault pins drive to factory trim
  assign useFactoryTrim = (selftestResult == MRF_ST_TO_RAIL) ||
                          (selftestResult == MRF_ST_TO_GND);
endmodule : mrf_selftest

// File: verification/mrf_ctrl_model.sv
// Controller model issuing mode register commands
`timescale 1ns/1ps
module mrf_ctrl_model
  import mrf_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic dqsOe,
  output logic      cmdValid,
  output logic      cmdIsWrite,
  output logic [7:0] modeRegAddress,
  output logic [7:0] operandBits
);
  logic       pend = 1'b0;
  logic       reqW = 1'b0;
  logic [7:0] reqA = 8'h00;
  logic [7:0] reqD = 8'h00;
  // ==========================================================
  // Line driver
  // Idle lines show the inverse so stale values never look valid
  always @(negedge ref_clk) begin
    if (pend) begin
      cmdValid <= 1'b1;
      cmdIsWrite <= reqW;
      modeRegAddress <= reqA;
      operandBits <= reqD;
      pend <= 1'b0;
    end else begin
      cmdValid <= 1'b0;
      cmdIsWrite <= ~reqW;
      modeRegAddress <= ~reqA;
      operandBits <= ~reqD;
    end
  end
  // ==========================================================
  // Commands
  task automatic issue(input logic w, input logic [7:0] a, d);
    reqW = w;
    reqA = a;
    reqD = d;
    pend = 1'b1;
    wait (pend == 1'b0);
    @(posedge ref_clk);
  endtask : issue
  task automatic wr(input logic [7:0] a, d);
    issue(1'b1, a, d);
  endtask : wr
  // Next read only after the burst ends
  task automatic rd(input logic [7:0] a);
    int n;
    issue(1'b0, a, 8'h00);
    for (n = 0; n < 40 && dqsOe !== 1'b1; n++) @(posedge ref_clk);
    for (n = 0; n < 8 && dqsOe === 1'b1; n++) @(posedge ref_clk);
  endtask : rd
endmodule : mrf_ctrl_model

// File: verification/mrf_mode_regs_sva.sv
// Checker of the mode register file ports
`timescale 1ns/1ps
module mrf_mode_regs_sva
  import mrf_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       cmdValid,
  input wire logic       cmdIsWrite,
  input wire logic [7:0] modeRegAddress,
  input wire logic [7:0] operandBits,
  input wire logic       dqsToggle,
  input wire logic       dqsOe,
  input wire logic [7:0] dqLow,
  input wire logic       autoInitStatus,
  input wire logic       useFactoryTrim,
  input wire logic       calBusy,
  input wire logic       dqCalActive,
  input wire logic [7:0] burstCfg,
  input wire logic [7:0] latencyCfg,
  input wire logic [7:0] srBankMask
);
  int unsigned initCnt_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Helpers
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !autoInitStatus) initCnt_r <= 0;
    else initCnt_r <= initCnt_r + 1;
  end
  sequence s_wr(logic [7:0] a);
    cmdValid && cmdIsWrite && modeRegAddress == a;
  endsequence
  sequence s_four_beats;
    dqsOe [*4] ##1 !dqsOe;
  endsequence
  // ==========================================================
  // Properties
  a_burst_write: assert property (s_wr(MRF_ADDR_BURST_CFG) |->
    ##2 burstCfg == $past(operandBits, 2)) else $error("burst cfg");
  a_lat_write: assert property (s_wr(MRF_ADDR_LATENCY_CFG) |->
    ##2 latencyCfg == $past(operandBits, 2)) else $error("latency cfg");
  a_ro_ignored: assert property (cmdValid && cmdIsWrite &&
    modeRegAddress inside {8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h20, 8'h28} |-> ##2 $stable(burstCfg) && $stable(latencyCfg)
    && $stable(srBankMask)) else $error("read-only write took effect");
  a_read_answer: assert property (cmdValid && !cmdIsWrite
    |-> ##[4:18] dqsOe) else $error("no read burst");
  a_burst_len: assert property ($rose(dqsOe) |-> s_four_beats)
    else $error("burst not four beats");
  a_strobe_toggle: assert property (dqsOe && $past(dqsOe)
    |-> dqsToggle != $past(dqsToggle)) else $error("strobe stuck");
  a_byte_steady: assert property (dqsOe && $past(dqsOe)
    |-> $stable(dqLow)) else $error("byte changed in burst");
  a_soft_reset: assert property (s_wr(MRF_ADDR_SOFT_RESET) |->
    ##3 autoInitStatus && burstCfg == 8'h00) else $error("no reset");
  a_init_bound: assert property (
    initCnt_r <= MRF_AUTO_INIT_CYC + 1) else $error("init too long");
  a_trim_lock: assert property (useFactoryTrim && cmdValid &&
    cmdIsWrite && modeRegAddress == MRF_ADDR_IMP_CAL |-> ##1 !calBusy [*4])
    else $error("calibration ran under factory trim");
  a_dq_cal: assert property (cmdValid && !cmdIsWrite &&
    modeRegAddress == MRF_ADDR_DQ_PAT_A |-> ##[1:4] dqCalActive)
    else $error("no dq calibration");
endmodule : mrf_mode_regs_sva
bind mrf_mode_regs mrf_mode_regs_sva u_sva (.ref_clk, .sys_rst, .cmdValid,
  .cmdIsWrite, .modeRegAddress, .operandBits, .dqsToggle, .dqsOe, .dqLow,
  .autoInitStatus, .useFactoryTrim, .calBusy, .dqCalActive, .burstCfg,
  .latencyCfg, .srBankMask);

// File: verification/tb_dram_mode_register_file.sv
// Testbench of the mode register file
`timescale 1ns/1ps
module tb_dram_mode_register_file;
  import mrf_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic calPinToRail = 1'b0;
  logic calPinToGnd = 1'b0;
  logic cmdValid, cmdIsWrite, dqsToggle, dqsOe, autoInitStatus;
  logic useFactoryTrim, calBusy, dqCalActive;
  logic [7:0] modeRegAddress, operandBits, dqLow, burstCfg, latencyCfg;
  logic [7:0] ioDriveCfg, srBankMask, srSegmentMask;
  logic [7:0] expQ[$];
  logic [39:0] cfgExp;
  int bad_count = 0;
  int check_count = 0;
  int seed = 32'h234ca612;
  int beat = 0;
  initial forever #12.5 ref_clk = ~ref_clk;
  mrf_mode_regs u_dut (.ref_clk, .sys_rst, .cmdValid, .cmdIsWrite,
    .modeRegAddress, .operandBits, .calPinToRail, .calPinToGnd, .dqsToggle,
    .dqsOe, .dqLow, .autoInitStatus, .useFactoryTrim, .calBusy, .dqCalActive,
    .burstCfg, .latencyCfg, .ioDriveCfg, .srBankMask, .srSegmentMask);
  mrf_ctrl_model u_ctrl (.ref_clk, .dqsOe, .cmdValid, .cmdIsWrite,
    .modeRegAddress, .operandBits);
  // ==========================================================
  // Checks and monitor
  task automatic chk(input logic [39:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : chk
  function automatic logic [39:0] cfg();
    return {burstCfg, latencyCfg, ioDriveCfg, srBankMask, srSegmentMask};
  endfunction : cfg
  always @(posedge ref_clk) begin
    if (dqsOe === 1'b1) begin
      if (expQ.size() == 0) chk(1, 0, "unexpected burst");
      else chk(dqLow, expQ[0], "read byte");
      beat++;
      if (beat == MRF_BURST_BEATS && expQ.size() > 0) void'(expQ.pop_front());
      if (beat == MRF_BURST_BEATS) beat = 0;
    end
  end
  task automatic rdx(input logic [7:0] a, exp);
    expQ.push_back(exp);
    u_ctrl.rd(a);
    chk(expQ.size(), 0, "read burst missing");
  endtask : rdx
  task automatic waitFor(ref logic s, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && s !== v; n++) @(negedge ref_clk);
    chk(s, v, "wait expired");
  endtask : waitFor
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    #(25 * 20000);
    bad_count++;
    summarize();
  end
  // ==========================================================
  // Scenarios
  logic [7:0] cfgA[5] = '{8'h01, 8'h02, 8'h03, 8'h10, 8'h11};
  logic [7:0] roA[8] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h20,
                         8'h28};
  logic [7:0] roV[8] = '{8'h00, MRF_REFRESH_VAL, MRF_VENDOR_ID,
    MRF_REV_ONE_VAL, MRF_REV_TWO_VAL, MRF_GEOMETRY_VAL, MRF_DQ_PAT_A_VAL,
    MRF_DQ_PAT_B_VAL};
  logic [7:0] undefA[7] = '{8'h01, 8'h0a, 8'h3f, 8'h0b, 8'h30, 8'h80, 8'hff};
  initial begin
    logic [7:0] v;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk(autoInitStatus, 1'b1, "init flag after reset");
    waitFor(autoInitStatus, 1'b0, MRF_AUTO_INIT_CYC + 2);
    rdx(MRF_ADDR_DEVICE_INFO, 8'h00);
    $display("test init done");
    // Back-to-back writes; only mapped writable addresses
    for (int i = 0; i < 5; i++) begin
      v = $random(seed);
      if (i == 1 || i == 2) v[7:4] = 4'h0;
      cfgExp[39 - 8 * i -: 8] = v;
      u_ctrl.wr(cfgA[i], v);
    end
    repeat (2) @(negedge ref_clk);
    chk(cfg(), cfgExp, "config write");
    $display("test config done");
    foreach (roA[i]) u_ctrl.wr(roA[i], $random(seed));
    repeat (3) @(negedge ref_clk);
    chk(cfg(), cfgExp, "read-only write");
    foreach (roA[i]) rdx(roA[i], roV[i]);
    foreach (undefA[i]) rdx(undefA[i], MRF_UNDEF_DATA);
    $display("test read map done");
    u_ctrl.wr(MRF_ADDR_IMP_CAL, MRF_CAL_INIT);
    waitFor(calBusy, 1'b1, 6);
    waitFor(calBusy, 1'b0, MRF_CAL_CYC + 10);
    rdx(MRF_ADDR_DEVICE_INFO, {3'h0, MRF_ST_OK, 3'h0});
    chk(useFactoryTrim, 1'b0, "trim with resistor");
    calPinToRail = 1'b1;
    repeat (4) @(negedge ref_clk);
    u_ctrl.wr(MRF_ADDR_IMP_CAL, MRF_CAL_INIT);
    waitFor(calBusy, 1'b1, 6);
    waitFor(calBusy, 1'b0, MRF_CAL_CYC + 10);
    rdx(MRF_ADDR_DEVICE_INFO, {3'h0, MRF_ST_TO_RAIL, 3'h0});
    chk(useFactoryTrim, 1'b1, "trim on rail");
    u_ctrl.wr(MRF_ADDR_IMP_CAL, MRF_CAL_LONG);
    repeat (4) @(negedge ref_clk);
    chk(calBusy, 1'b0, "calibration while trimmed");
    $display("test calibration done");
    u_ctrl.wr(MRF_ADDR_SOFT_RESET, $random(seed));
    repeat (3) @(negedge ref_clk);
    chk(autoInitStatus, 1'b1, "soft reset flag");
    chk(cfg(), {5{MRF_RST_CFG}}, "soft reset config");
    waitFor(autoInitStatus, 1'b0, MRF_AUTO_INIT_CYC + 2);
    $display("test soft reset done");
    summarize();
  end
endmodule : tb_dram_mode_register_file
